// [src/esta_pkg.sv]
`default_nettype none
// ****************************************************************
// Shared constants of the emergency-stop terminal assignment block
// ****************************************************************
package esta_pkg;

	// Geometry
	localparam int NUM_TERM = 8;
	localparam int IDX_W    = 4;
	localparam int T1_IDX   = 0;                // Terminal 1
	localparam int T3_IDX   = 2;                // Terminal 3

	// Function codes
	localparam logic [7:0] FUNC_JOG   = 8'h06;  // 06
	localparam logic [7:0] FUNC_RESET = 8'h12;  // 18
	localparam logic [7:0] FUNC_EMR   = 8'h40;  // 64
	localparam logic [7:0] FUNC_NONE  = 8'hFF;  // No function assigned

	// Polarity selections
	localparam logic [1:0] POL_NO = 2'h0;       // 00, normally open
	localparam logic [1:0] POL_NC = 2'h1;       // 01, normally closed

	// Trip codes
	localparam logic [7:0] TRIP_NONE  = 8'h00;
	localparam logic [7:0] TRIP_ESTOP = 8'h25;  // 37

	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h04;
	localparam logic [7:0] OFS_FLAGS  = 8'h08;
	localparam logic [7:0] OFS_INPUTS = 8'h0C;
	localparam logic [1:0] PAGE_FUNC  = 2'h1;   // 0x40 + 4*terminal
	localparam logic [1:0] PAGE_POL   = 2'h2;   // 0x80 + 4*terminal

	// Field positions
	localparam int CTRL_COPY  = 0;
	localparam int CTRL_PCLR  = 1;
	localparam int FLAG_COPY  = 0;
	localparam int FLAG_REFUS = 1;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Trip state machine
	typedef enum logic [1:0] {
		ESTA_RUN  = 2'b01,
		ESTA_TRIP = 2'b10
	} esta_trip_state_type;

	// Reset function code of a terminal
	function automatic logic [7:0] func_rst(input int i);
		func_rst = (i == T1_IDX) ? FUNC_RESET :
			(i == T3_IDX) ? FUNC_JOG : FUNC_NONE;
	endfunction

endpackage
`default_nettype wire

// [src/esta_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Carrier between register front end and terminal table
// ****************************************************************
interface esta_cfg_if #(parameter int N = 8, parameter int IW = 4);
	logic                wr_en;    // One-cycle write strobe
	logic                sel_pol;  // Write targets polarity, else function
	logic [IW-1:0]       idx;
	logic [7:0]          data;
	logic                sw_on;
	logic                sw_rise;
	logic                sw_fall;
	wire  [N-1:0][7:0]   func;     // One driver per entry
	wire  [N-1:0][1:0]   pol;

	modport ctl (output wr_en, sel_pol, idx, data, sw_on, sw_rise,
		sw_fall, input func, pol);
	modport tbl (input wr_en, sel_pol, idx, data, sw_on, sw_rise,
		sw_fall, output func, pol);
endinterface
`default_nettype wire

// [src/esta_term_cfg.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Terminal function and polarity table
// ****************************************************************
module esta_term_cfg #(
	parameter int N = esta_pkg::NUM_TERM
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	esta_cfg_if.tbl   cfg
);
	import esta_pkg::*;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_term
			logic [7:0] func_r;
			logic [7:0] func_nxt;
			logic [1:0] pol_r;
			logic [1:0] pol_nxt;
			logic       locked;
			logic       hit;

			assign locked = cfg.sw_on && (i == T1_IDX || i == T3_IDX);
			assign hit    = cfg.wr_en && !locked &&
				(cfg.idx == IDX_W'(i));

			// Next assignment, switch edges first
			always_comb begin
				func_nxt = func_r;
				pol_nxt  = pol_r;
				if (cfg.sw_rise) begin
					if (i == T1_IDX) begin
						func_nxt = FUNC_RESET; // R01 R02
						pol_nxt  = POL_NO;     // R02
					end else if (i == T3_IDX) begin
						func_nxt = FUNC_EMR;   // R01 R03
						pol_nxt  = POL_NC;     // R03
					end else if (func_r == FUNC_RESET) begin
						func_nxt = FUNC_NONE;  // R08
					end
				end else if (cfg.sw_fall && i == T3_IDX) begin
					func_nxt = FUNC_NONE;      // R09
				end else if (hit && !cfg.sel_pol) begin
					if (!(i == T3_IDX && cfg.data == FUNC_EMR))
						func_nxt = cfg.data;   // R07 R12
				end else if (hit && cfg.sel_pol) begin
					pol_nxt = cfg.data[1:0];   // R07
				end
				// Forced polarities
				if (func_nxt == FUNC_RESET)
					pol_nxt = POL_NO;          // R10
				if (i == T3_IDX && func_nxt == FUNC_EMR)
					pol_nxt = POL_NC;          // R11
			end

			// Table entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					func_r <= func_rst(i);     // R07
					pol_r  <= POL_NO;          // R07
				end else if (ce) begin
					func_r <= func_nxt;
					pol_r  <= pol_nxt;
				end
			end

			assign cfg.func[i] = func_r;
			assign cfg.pol[i]  = pol_r;
		end
	endgenerate

endmodule // esta_term_cfg
`default_nettype wire

// [src/esta_trip.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Emergency-stop trip latch and switching gate
// ****************************************************************
module esta_trip (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       stop_req,
	input  wire logic       clear_req,
	output var  logic       tripped_r,
	output var  logic       switch_en_r,
	output var  logic [7:0] trip_code_r
);
	import esta_pkg::*;

	esta_trip_state_type state_r;
	esta_trip_state_type state_nxt;

	// Stop wins over a clear in the same cycle
	always_comb begin
		case (state_r)
			ESTA_RUN:  state_nxt = stop_req ? ESTA_TRIP : ESTA_RUN; // R04
			ESTA_TRIP: state_nxt = (clear_req && !stop_req) ?
				ESTA_RUN : ESTA_TRIP;                              // R06 R14
			default:   state_nxt = ESTA_TRIP;
		endcase
	end

	// State and outputs, no processor in the path
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= ESTA_RUN;
			tripped_r   <= 1'b0;
			switch_en_r <= 1'b1;
			trip_code_r <= TRIP_NONE;
		end else if (ce) begin
			state_r     <= state_nxt;
			tripped_r   <= (state_nxt == ESTA_TRIP);   // R14
			switch_en_r <= (state_nxt == ESTA_RUN);    // R03 R04
			trip_code_r <= (state_nxt == ESTA_TRIP) ?
				TRIP_ESTOP : TRIP_NONE;                // R04
		end
	end

endmodule // esta_trip
`default_nettype wire

// [src/esta_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Emergency-stop terminal assignment, APB register front end
// ****************************************************************

// Behaviour
// R01: Switch on reserves terminals 1, 3 exclusively
// R02: Terminal 1 fixed reset 18, polarity 00
// R03: Terminal 3 fixed stop 64/01, hardware cut
// R04: Active stop trips, code 37, switching halted
// R05: Open or miswired terminal 3 trips
// R06: Only terminal 1 reset clears; panel refused
// R07: Switch off: free assignment, 18/06 defaults
// R08: Switch on clears duplicate reset elsewhere
// R09: Switch off keeps rewritten assignments, except the terminal 3 function, which is cleared to FF
// R10: Reset function forces polarity 00
// R11: Stop function on terminal 3 forces 01
// R12: Operator cannot assign 64 to terminal 3
// R13: Copy skips terminals 1, 3, flags error
// R14: Trip latches until synchronised terminal 1 reset
module esta_top #(
	parameter int N = esta_pkg::NUM_TERM
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output var  logic [31:0]  prdata,
	output var  logic         pready,
	output var  logic         pslverr,
	// Drive side
	input  wire logic         estop_enable_switch,
	input  wire logic [N-1:0] terminal_in,
	output var  logic [N-1:0] terminal_active,
	output var  logic         switching_enable,
	output var  logic         emergency_trip,
	output var  logic [7:0]   emergency_trip_code,
	output var  logic         copy_error
);
	import esta_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	esta_cfg_if #(.N(N), .IW(IDX_W)) cfg ();

	logic         pready_r;
	logic         pslverr_r;
	logic [31:0]  prdata_r;
	logic [31:0]  prdata_nxt;
	logic [7:0]   ctrl_r;
	logic         copy_flag_r;
	logic         refus_flag_r;
	logic         sw_q_r;
	logic [N-1:0] act_r;
	logic         stop_now;
	logic         clear_now;
	logic         tripped;
	logic         switch_en;
	logic [7:0]   trip_code;

	// ************************************************************
	// APB decode
	// ************************************************************
	wire          setup      = psel && !penable && !pready_r;
	wire          acc        = psel && penable && pready_r;
	wire          wr         = acc && pwrite;
	wire [IDX_W-1:0] idx     = paddr[IDX_W+1:2];
	wire          idx_ok     = ({4'h0, idx} < 8'(N)) && (paddr[1:0] == 2'h0);
	wire          page_func  = (paddr[7:6] == PAGE_FUNC) && idx_ok;
	wire          page_pol   = (paddr[7:6] == PAGE_POL) && idx_ok;
	wire          sel_status = (paddr == OFS_STATUS);
	wire          sel_ctrl   = (paddr == OFS_CTRL);
	wire          sel_flags  = (paddr == OFS_FLAGS);
	wire          sel_inputs = (paddr == OFS_INPUTS);
	wire          mapped     = sel_status || sel_ctrl || sel_flags ||
		sel_inputs || page_func || page_pol;

	// Table write classification
	wire          tbl_wr     = wr && (page_func || page_pol);
	wire          copy_mode  = ctrl_r[CTRL_COPY];
	wire          locked_idx = sw_q_r &&
		(idx == IDX_W'(T1_IDX) || idx == IDX_W'(T3_IDX));
	wire          emr_try    = page_func && (idx == IDX_W'(T3_IDX)) &&
		(pwdata[7:0] == FUNC_EMR);
	wire          skip_copy  = tbl_wr && copy_mode && locked_idx;   // R13
	wire          refuse_op  = tbl_wr && !copy_mode &&
		(locked_idx || emr_try);                                   // R01 R12
	wire          panel_clr  = wr && sel_ctrl && pwdata[CTRL_PCLR];
	wire          panel_ref  = panel_clr && tripped;               // R06

	// ************************************************************
	// Switch edges and input polarity
	// ************************************************************
	wire          sw_rise    = estop_enable_switch && !sw_q_r;
	wire          sw_fall    = !estop_enable_switch && sw_q_r;

	// Per-terminal active level from the polarity selection
	wire  [N-1:0] act_nxt;
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_act
			assign act_nxt[gi] = terminal_in[gi] ^ cfg.pol[gi][0];
		end
	endgenerate

	// Terminal 3 is read as normally closed directly, so a floating
	// or low input trips even before the table has settled
	assign stop_now  = estop_enable_switch && !terminal_in[T3_IDX]; // R03 R05
	// Reset only from terminal 1, on the registered rising edge
	assign clear_now = act_nxt[T1_IDX] && !act_r[T1_IDX] &&
		(cfg.func[T1_IDX] == FUNC_RESET);                        // R06 R14

	// ************************************************************
	// Table port drive
	// ************************************************************
	assign cfg.wr_en   = tbl_wr && !refuse_op && !skip_copy;
	assign cfg.sel_pol = page_pol;
	assign cfg.idx     = idx;
	assign cfg.data    = pwdata[7:0];
	assign cfg.sw_on   = sw_q_r;
	assign cfg.sw_rise = sw_rise;
	assign cfg.sw_fall = sw_fall;

	// ************************************************************
	// Read data
	// ************************************************************
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (sel_status) begin
			prdata_nxt[0]    = sw_q_r;
			prdata_nxt[1]    = tripped;
			prdata_nxt[2]    = switch_en;
			prdata_nxt[15:8] = trip_code;
		end else if (sel_ctrl) begin
			prdata_nxt[7:0] = ctrl_r;
		end else if (sel_flags) begin
			prdata_nxt[FLAG_COPY]  = copy_flag_r;
			prdata_nxt[FLAG_REFUS] = refus_flag_r;
		end else if (sel_inputs) begin
			prdata_nxt[N-1:0] = act_r;
		end else if (page_func) begin
			prdata_nxt[7:0] = cfg.func[idx];
		end else if (page_pol) begin
			prdata_nxt[1:0] = cfg.pol[idx];
		end
	end

	// ************************************************************
	// Submodules
	// ************************************************************
	esta_term_cfg #(.N(N)) u_cfg (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.cfg   (cfg.tbl)
	);

	esta_trip u_trip (
		.clk         (clk),
		.rst_n       (rst_n),
		.ce          (ce),
		.stop_req    (stop_now),
		.clear_req   (clear_now),
		.tripped_r   (tripped),
		.switch_en_r (switch_en),
		.trip_code_r (trip_code)
	);

	// ************************************************************
	// APB answer, one wait-free access after setup
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (ce) begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
			if (setup)
				prdata_r <= prdata_nxt;
		end
	end

	// ************************************************************
	// Control register and sticky flags
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
		end else if (ce && wr && sel_ctrl) begin
			ctrl_r <= {7'h00, pwdata[CTRL_COPY]};
		end
	end

	// Hardware set wins over a software write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			copy_flag_r  <= 1'b0;
			refus_flag_r <= 1'b0;
		end else if (ce) begin
			copy_flag_r  <= skip_copy || (copy_flag_r &&
				!(wr && sel_flags && pwdata[FLAG_COPY]));          // R13
			refus_flag_r <= refuse_op || panel_ref || (refus_flag_r &&
				!(wr && sel_flags && pwdata[FLAG_REFUS]));         // R06 R12
		end
	end

	// ************************************************************
	// Switch sample and input sample
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_q_r <= 1'b0;
			act_r  <= '0;
		end else if (ce) begin
			sw_q_r <= estop_enable_switch;                         // R08 R09
			act_r  <= act_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata              = prdata_r;
	assign pready              = pready_r;
	assign pslverr             = pslverr_r;
	assign terminal_active     = act_r;
	assign switching_enable    = switch_en;
	assign emergency_trip      = tripped;
	assign emergency_trip_code = trip_code;
	assign copy_error          = copy_flag_r;

endmodule // esta_top
`default_nettype wire

// [dv/esta_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker of the terminal block
// ****
module esta_properties #(
	parameter int N = 8
) (
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic         ce,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [7:0]   paddr,
	input wire logic [31:0]  pwdata,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         estop_enable_switch,
	input wire logic [N-1:0] terminal_in,
	input wire logic [N-1:0] terminal_active,
	input wire logic         switching_enable,
	input wire logic         emergency_trip,
	input wire logic [7:0]   emergency_trip_code,
	input wire logic         copy_error
);
	import esta_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Stop input with switch on trips next cycle
	stop_trips_a: assert property (
		ce && estop_enable_switch && !terminal_in[T3_IDX] |=> emergency_trip)
		else $error("stop input did not trip");
	// Trip code follows trip level
	trip_code_a: assert property (
		emergency_trip_code == (emergency_trip ? TRIP_ESTOP : TRIP_NONE))
		else $error("trip code wrong");
	// Switching stays halted while tripped
	halt_out_a: assert property (
		switching_enable == !emergency_trip)
		else $error("switching enable wrong");
	// Trip holds until a reset edge on terminal 1
	trip_hold_a: assert property (
		emergency_trip && !(terminal_in[T1_IDX] && !$past(terminal_in[T1_IDX]))
		|=> emergency_trip) else $error("trip dropped");
	// Reset edge on terminal 1 clears once stop is gone
	trip_clear_a: assert property (
		ce && emergency_trip && estop_enable_switch && $past(estop_enable_switch)
		&& terminal_in[T3_IDX] && terminal_in[T1_IDX]
		&& !$past(terminal_in[T1_IDX]) |=> !emergency_trip)
		else $error("trip not cleared");
	// Fixed polarities of terminals 1 and 3 while enabled
	fixed_pol_a: assert property (
		estop_enable_switch && $past(estop_enable_switch, 2) && $past(rst_n, 2)
		|-> terminal_active[T1_IDX] == $past(terminal_in[T1_IDX])
		&& terminal_active[T3_IDX] == !$past(terminal_in[T3_IDX]))
		else $error("fixed polarity wrong");
	// Copy error flag is sticky
	copy_keep_a: assert property (
		copy_error && !(psel && penable && pwrite && paddr == OFS_FLAGS
		&& pwdata[FLAG_COPY]) |=> copy_error) else $error("copy flag lost");
	// Zero wait-state answer
	apb_ready_a: assert property (
		ce && psel && !penable |=> pready) else $error("no ready");
	// Error only with ready
	err_ready_a: assert property (
		pslverr |-> pready) else $error("error without ready");
endmodule // esta_properties
`default_nettype wire

// [dv/esta_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// External safety controller on the terminals
// ****
module esta_ctrl_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       stop_cmd,
	input  wire logic       clear_cmd,
	output var  logic [7:0] term_out
);
	// NC stop line high when healthy, NO reset line pulses to clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			term_out <= 8'h04;
		else
			term_out <= {5'h00, !stop_cmd, 1'b0, clear_cmd};
	end
endmodule // esta_ctrl_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
	tests_run++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("[ERR] %0t got %0h want %0h", $time, a, e); \
	end \
end
module tb_top;
	import esta_pkg::*;
	typedef struct {
		logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;
	} esta_row_type;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic        estop_enable_switch, switching_enable, emergency_trip;
	logic        copy_error, stop_c, clr_c;
	logic [7:0]  paddr, emergency_trip_code, terminal_in, terminal_active;
	logic [31:0] pwdata, prdata, rd;
	int          bad_count, tests_run;
	esta_row_type rows[14] = '{
		'{0, 8'h40, 0, 32'h12, 0},
		'{0, 8'h48, 0, 32'h06, 0},
		'{0, 8'h88, 0, 32'h00, 0},
		'{0, 8'h44, 0, 32'hFF, 0},
		'{0, 8'h00, 0, 32'h04, 0},
		'{1, 8'h44, 32'h12, 0, 0},
		'{1, 8'h84, 32'h01, 0, 0},
		'{0, 8'h84, 0, 32'h00, 0},
		'{1, 8'h48, 32'h40, 0, 0},
		'{0, 8'h48, 0, 32'h06, 0},
		'{0, 8'h08, 0, 32'h02, 0},
		'{1, 8'h08, 32'h03, 0, 0},
		'{0, 8'h08, 0, 32'h00, 0},
		'{0, 8'hF0, 0, 32'h00, 1}};

	esta_top #(.N(8)) dut_u (.clk, .rst_n, .ce(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.estop_enable_switch, .terminal_in, .terminal_active,
		.switching_enable, .emergency_trip, .emergency_trip_code,
		.copy_error);
	esta_ctrl_model ctl_u (.clk, .rst_n, .stop_cmd(stop_c),
		.clear_cmd(clr_c), .term_out(terminal_in));

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// APB transfer, waits on ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Sample ready at each access edge, before it can fall
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) `CHK(pready, 1'b1)
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// Bounded wait on the trip level
	task wtrip(input logic v);
		int n;
		n = 0;
		while (emergency_trip !== v && n < 10) begin
			@(posedge clk);
			n++;
		end
		`CHK(emergency_trip, v)
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog
	initial begin
		#200000;
		bad_count++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, estop_enable_switch} = 5'h00;
		{stop_c, clr_c, paddr, pwdata, bad_count, tests_run} = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) `CHK(rd, rows[i].e)
			`CHK(er, rows[i].er)
		end
		$display("test table done");
		@(posedge clk) estop_enable_switch <= 1'b1;
		rchk(8'h44, 32'hFF);
		rchk(8'h40, 32'h12);
		rchk(8'h80, 32'h00);
		rchk(8'h48, 32'h40);
		rchk(8'h88, 32'h01);
		wr(8'h40, 32'h06);
		rchk(8'h40, 32'h12);
		wr(8'h88, 32'h00);
		rchk(8'h88, 32'h01);
		$display("test assign done");
		@(posedge clk) stop_c <= 1'b1;
		wtrip(1'b1);
		`CHK(emergency_trip_code, TRIP_ESTOP)
		`CHK(switching_enable, 1'b0)
		@(posedge clk) clr_c <= 1'b1;
		@(posedge clk) clr_c <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(emergency_trip, 1'b1)
		@(posedge clk) stop_c <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(emergency_trip, 1'b1)
		wr(8'h08, 32'h03);
		wr(8'h04, 32'h02);
		`CHK(emergency_trip, 1'b1)
		rchk(8'h08, 32'h02);
		@(posedge clk) clr_c <= 1'b1;
		wtrip(1'b0);
		@(posedge clk) clr_c <= 1'b0;
		`CHK(switching_enable, 1'b1)
		$display("test trip done");
		wr(8'h04, 32'h01);
		wr(8'h40, 32'h06);
		rchk(8'h40, 32'h12);
		`CHK(copy_error, 1'b1)
		wr(8'h4C, 32'h06);
		rchk(8'h4C, 32'h06);
		wr(8'h04, 32'h00);
		$display("test copy done");
		@(posedge clk) estop_enable_switch <= 1'b0;
		rchk(8'h48, 32'hFF);
		rchk(8'h88, 32'h01);
		rchk(8'h40, 32'h12);
		rchk(8'h44, 32'hFF);
		wr(8'h48, 32'h06);
		rchk(8'h48, 32'h06);
		$display("test release done");
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		`CHK(copy_error, 1'b0)
		rchk(8'h44, 32'hFF);
		$display("test reset done");
		tally_and_finish;
	end
endmodule // tb_top
bind esta_top esta_properties #(.N(N)) chk_u (.clk, .rst_n, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.estop_enable_switch, .terminal_in, .terminal_active,
	.switching_enable, .emergency_trip, .emergency_trip_code, .copy_error);
`default_nettype wire
